/* File: uds_pkg.sv */
`default_nettype none
package uds_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned T_IDLE_US = 3000;
  localparam int unsigned T_POWER_OFF_SUSPEND_MODE_US = 2000;
  localparam int unsigned T_RWAKE_US = 10000;
  localparam int unsigned T_WAKE_MAX_US = 15000;
  localparam int unsigned TMR_W = 21;
  // Idle must last more than the limit, so one extra cycle
  localparam int unsigned IDLE_CYC = T_IDLE_US * CLK_KHZ / 1000 + 1;
  localparam int unsigned POWER_OFF_SUSPEND_MODE_CYC = T_POWER_OFF_SUSPEND_MODE_US * CLK_KHZ / 1000;
  localparam int unsigned RWAKE_CYC = T_RWAKE_US * CLK_KHZ / 1000;
  localparam int unsigned WAKE_MAX_CYC = T_WAKE_MAX_US * CLK_KHZ / 1000;
  // Oscillator wait leaves room for the K-state inside the wake limit
  localparam int unsigned OSC_TMO_CYC = WAKE_MAX_CYC - RWAKE_CYC - 4;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_HW_CONFIG = 8'h0c;
  localparam logic [7:0] ADDR_UNLOCK = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;
  localparam int unsigned BIT_SUSP = 0;
  localparam int unsigned BIT_RESM = 1;
  localparam int unsigned BIT_LINE_IDLE = 2;
  localparam logic [15:0] UNLOCK_KEY = 16'haa37;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [3:0] HWCFG_RST = 4'h8;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_AWAKE = 5'h01,
    ST_SUSP_WAIT = 5'h02,
    ST_SUSPENDED = 5'h04,
    ST_WAKE_OSC = 5'h08,
    ST_REMOTE_K = 5'h10
  } uds_state_t;

  typedef struct packed {
    logic clock_keepalive;
    logic power_off_suspend_mode;
    logic select_wake_enable;
    logic pullup_source_select;
  } uds_hwcfg_t;

  typedef struct packed {
    logic suspend_entry_strobe;
    logic internal_pullup_connect;
  } uds_mode_t;

  typedef struct packed {
    logic resume_irq_enable;
    logic suspend_irq_enable;
  } uds_mask_t;
endpackage
`default_nettype wire

/* File: uds_suspend_resume.sv */
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Contract
// RQ1: Host K-state while suspended starts the wake-up sequence.
// RQ2: High wake request while suspended starts a remote wake-up.
// RQ3: Low chip select wakes only if enabled and bus supply present.
// RQ4: Oscillator enabled first; clocks distributed only once stable. Code also distributes them after the OSC_TMO_CYC_P timeout.
// RQ5: With clocks running, suspend output drops and resume flag sets.
// RQ6: Resume flag raises interrupt only when its enable is set.
// RQ7: Normal operation restored within 15 ms of wake start.
// RQ8: Application wake drives K-state on the bus for 10 ms.
// RQ9: Application restores system after suspend output drops.
// RQ10: After wake-up, register writes ignored until unlocked.
// RQ11: Writing key AA37H to unlock command re-enables writes.
// RQ12: Awake-to-suspend bus transition sets the suspend event flag.
// RQ13: Live line idle status reads 1 while bus is suspended.
// RQ14: Suspend flag raises interrupt only when its enable is set.
// RQ15: Suspend entered on falling edge of the entry strobe bit.
// RQ16: Connect bit controls attaching the internal pull-up.
// RQ17: Config bit selects internal or external pull-up.
// RQ18: Config bit selects powered-off suspend mode switching power.
// RQ19: Bus suspend detected after more than 3 ms idle.
// RQ20: Powered-off mode asserts suspend and stops clocks 2 ms after strobe.
// RQ21: Firmware clears clock keep-alive before suspend.
// RQ22: Remote K-state starts after clocks stable, timed by device clock. Code also starts it after the OSC_TMO_CYC_P timeout.
module uds_suspend_resume
  import uds_pkg::*;
#(
  parameter logic [TMR_W-1:0] IDLE_CYC_P = TMR_W'(IDLE_CYC),
  parameter logic [TMR_W-1:0] POWER_OFF_SUSPEND_MODE_CYC_P = TMR_W'(POWER_OFF_SUSPEND_MODE_CYC),
  parameter logic [TMR_W-1:0] RWAKE_CYC_P = TMR_W'(RWAKE_CYC),
  parameter logic [TMR_W-1:0] OSC_TMO_CYC_P = TMR_W'(OSC_TMO_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic line_idle,
  input wire logic line_k,
  input wire logic wake_req,
  input wire logic cs_n,
  input wire logic vbus,
  input wire logic osc_stable,
  output logic osc_enable,
  output logic clk_gate,
  output logic suspend_out,
  output logic power_switch_off,
  output logic bus_k_drive,
  output logic pullup_int_en,
  output logic pullup_ext_en,
  output logic irq
);
  // ==========================================================
  // Input synchronisers
  logic [5:0] sync1, sync2;
  logic s_line_idle, s_line_k, s_wake_req;
  logic s_cs_n, s_vbus, s_osc_stable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {osc_stable, vbus, cs_n, wake_req, line_k, line_idle};
      sync2 <= sync1;
    end
  end
  assign {s_osc_stable, s_vbus, s_cs_n, s_wake_req, s_line_k, s_line_idle} = sync2;

  // ==========================================================
  // Bus slave
  logic ap_valid, ap_wr;
  logic [ADDR_W-1:0] ap_addr;
  logic wr_en;
  logic wr_allowed;
  logic locked;
  uds_mask_t mask;
  uds_mode_t mode;
  uds_hwcfg_t hwcfg;
  logic sus_flag;
  logic resm_flag;
  logic line_susp;
  uds_state_t state;
  logic [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_wr <= hsel && htrans[1] && hwrite;
      ap_addr <= haddr[ADDR_W-1:0];
    end
  end

  assign wr_en = ap_valid && ap_wr;
  // Lock blocks writes
  assign wr_allowed = wr_en && (!locked || ap_addr == ADDR_UNLOCK);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[ADDR_W-1:0])
      ADDR_IRQ_STATUS: rd_mux = {29'h0, line_susp, resm_flag, sus_flag};
      ADDR_IRQ_MASK: rd_mux = {30'h0, mask};
      ADDR_MODE: rd_mux = {30'h0, mode};
      ADDR_HW_CONFIG: rd_mux = {28'h0, hwcfg};
      ADDR_STATE: rd_mux = {26'h0, locked, state};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ==========================================================
  // Control registers
  logic strobe_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= MASK_RST;
      mode <= MODE_RST;
      hwcfg <= HWCFG_RST;
    end else if (wr_allowed) begin
      case (ap_addr)
        ADDR_IRQ_MASK: mask <= hwdata[1:0];
        ADDR_MODE: mode <= hwdata[1:0];
        ADDR_HW_CONFIG: hwcfg <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // RQ15 falling strobe edge
  assign strobe_fall = wr_allowed && ap_addr == ADDR_MODE && mode.suspend_entry_strobe &&
                       !hwdata[1];

  // RQ16 RQ17 pull-up steering
  assign pullup_int_en = mode.internal_pullup_connect && !hwcfg.pullup_source_select;
  assign pullup_ext_en = mode.internal_pullup_connect && hwcfg.pullup_source_select;

  // ==========================================================
  // Bus idle detection
  logic [TMR_W-1:0] idle_cnt;
  logic susp_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= '0;
    end else if (!s_line_idle) begin
      idle_cnt <= '0;
    end else if (idle_cnt != IDLE_CYC_P) begin
      idle_cnt <= idle_cnt + TMR_W'(1);
    end
  end

  // RQ19 RQ13 idle beyond limit
  assign line_susp = idle_cnt == IDLE_CYC_P;
  assign susp_evt = s_line_idle && idle_cnt == IDLE_CYC_P - TMR_W'(1);

  // ==========================================================
  // Wake sequencer
  logic [TMR_W-1:0] tmr;
  logic remote;
  logic wake_host;
  logic wake_app;
  logic osc_done;
  logic wake_done;

  // RQ1 RQ2 RQ3 wake sources
  assign wake_host = s_line_k;
  assign wake_app = s_wake_req || (!s_cs_n && hwcfg.select_wake_enable && s_vbus);
  assign osc_done = s_osc_stable || tmr == OSC_TMO_CYC_P - TMR_W'(1);
  assign wake_done = state == ST_WAKE_OSC && osc_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_AWAKE;
      tmr <= '0;
      remote <= 1'b0;
    end else begin
      tmr <= tmr + TMR_W'(1);
      case (state)
        ST_AWAKE: begin
          tmr <= '0;
          if (strobe_fall) begin
            // RQ20 RQ18 powered-off delay
            state <= hwcfg.power_off_suspend_mode ? ST_SUSP_WAIT : ST_SUSPENDED;
          end
        end
        ST_SUSP_WAIT: begin
          if (tmr == POWER_OFF_SUSPEND_MODE_CYC_P - TMR_W'(1)) begin
            state <= ST_SUSPENDED;
          end
        end
        ST_SUSPENDED: begin
          tmr <= '0;
          if (wake_host || wake_app) begin
            state <= ST_WAKE_OSC;
            remote <= wake_app && !wake_host;
          end
        end
        ST_WAKE_OSC: begin
          // RQ4 RQ7 wait for oscillator
          if (osc_done) begin
            tmr <= '0;
            state <= remote ? ST_REMOTE_K : ST_AWAKE;
          end
        end
        ST_REMOTE_K: begin
          // RQ8 RQ22 timed K-state
          if (tmr == RWAKE_CYC_P - TMR_W'(1)) begin
            state <= ST_AWAKE;
          end
        end
        default: state <= ST_AWAKE;
      endcase
    end
  end

  // RQ4 gated clocks
  assign osc_enable = state != ST_SUSPENDED || hwcfg.clock_keepalive;
  assign clk_gate = state == ST_AWAKE || state == ST_SUSP_WAIT || state == ST_REMOTE_K;
  // RQ5 suspend output
  assign suspend_out = state == ST_SUSPENDED || state == ST_WAKE_OSC;
  assign power_switch_off = suspend_out && hwcfg.power_off_suspend_mode;
  assign bus_k_drive = state == ST_REMOTE_K;

  // ==========================================================
  // Event flags, lock and interrupt
  logic clr_wr;

  assign clr_wr = wr_allowed && ap_addr == ADDR_IRQ_STATUS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sus_flag <= 1'b0;
      resm_flag <= 1'b0;
    end else begin
      // RQ12 suspend event
      sus_flag <= susp_evt || (sus_flag && !(clr_wr && hwdata[BIT_SUSP]));
      // RQ5 resume event
      resm_flag <= wake_done || (resm_flag && !(clr_wr && hwdata[BIT_RESM]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked <= 1'b0;
    end else if (wake_done) begin
      // RQ10 lock on wake
      locked <= 1'b1;
    end else if (wr_en && ap_addr == ADDR_UNLOCK && hwdata[15:0] == UNLOCK_KEY) begin
      // RQ11 unlock key
      locked <= 1'b0;
    end
  end

  // RQ6 RQ14 masked interrupt
  assign irq = (resm_flag && mask.resume_irq_enable) || (sus_flag && mask.suspend_irq_enable);

  // ==========================================================
  // Checks
  logic [TMR_W-1:0] wake_cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt <= '0;
    end else if (state == ST_WAKE_OSC || state == ST_REMOTE_K) begin
      wake_cnt <= wake_cnt + TMR_W'(1);
    end else begin
      wake_cnt <= '0;
    end
  end

  property p_wake_host;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SUSPENDED && s_line_k |=> state == ST_WAKE_OSC && !remote;
  endproperty
  a_wake_host: assert property (p_wake_host) else $error("host resume missed"); // RQ1

  property p_wake_app;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SUSPENDED && s_wake_req && !s_line_k |=> state == ST_WAKE_OSC && remote;
  endproperty
  a_wake_app: assert property (p_wake_app) else $error("remote wake missed"); // RQ2

  property p_cs_gate;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_SUSPENDED && !s_line_k && !s_wake_req &&
      !(hwcfg.select_wake_enable && s_vbus) |=> state == ST_SUSPENDED;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("unqualified wake"); // RQ3

  property p_clk_order;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_WAKE_OSC && !osc_done |=> !clk_gate && state == ST_WAKE_OSC;
  endproperty
  a_clk_order: assert property (p_clk_order) else $error("clock before stable"); // RQ4

  property p_resume;
    @(posedge hclk) disable iff (!hresetn)
    wake_done |=> resm_flag && !suspend_out && clk_gate && locked;
  endproperty
  a_resume: assert property (p_resume) else $error("resume step wrong"); // RQ5

  property p_irq_mask;
    @(posedge hclk) disable iff (!hresetn)
    !mask.resume_irq_enable && !(sus_flag && mask.suspend_irq_enable) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq not masked"); // RQ6

  property p_wake_bound;
    @(posedge hclk) disable iff (!hresetn)
    wake_cnt <= OSC_TMO_CYC_P + RWAKE_CYC_P && wake_cnt <= TMR_W'(WAKE_MAX_CYC);
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("wake too long"); // RQ7

  property p_k_len;
    @(posedge hclk) disable iff (!hresetn)
    $fell(bus_k_drive) |-> $past(tmr) == RWAKE_CYC_P - TMR_W'(1);
  endproperty
  a_k_len: assert property (p_k_len) else $error("K-state length wrong"); // RQ8

  property p_locked;
    @(posedge hclk) disable iff (!hresetn)
    locked && wr_en && ap_addr == ADDR_IRQ_MASK |=> $stable(mask);
  endproperty
  a_locked: assert property (p_locked) else $error("write while locked"); // RQ10

  property p_unlock;
    @(posedge hclk) disable iff (!hresetn)
    !wake_done && wr_en && ap_addr == ADDR_UNLOCK && hwdata[15:0] == UNLOCK_KEY |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed"); // RQ11

  property p_susp_flag;
    @(posedge hclk) disable iff (!hresetn)
    susp_evt |=> sus_flag && line_susp;
  endproperty
  a_susp_flag: assert property (p_susp_flag) else $error("suspend flag missed"); // RQ12

  property p_strobe;
    @(posedge hclk) disable iff (!hresetn)
    state == ST_AWAKE && !strobe_fall |=> state == ST_AWAKE;
  endproperty
  a_strobe: assert property (p_strobe) else $error("suspend without edge"); // RQ15

endmodule
`default_nettype wire

/* File: uds_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module uds_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic idle_cmd,
  input wire logic resume_cmd,
  input wire logic bus_k_drive,
  output logic line_idle,
  output logic line_k,
  output logic [15:0] k_len,
  output logic [7:0] k_runs
);
  logic [15:0] run;
  // ==========================================================
  // Line levels seen by the device
  // host global resume
  assign line_k = resume_cmd;
  assign line_idle = idle_cmd & ~resume_cmd & ~bus_k_drive;
  // ==========================================================
  // Remote wake K-state length
  // measure K
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 16'h0000;
      k_len <= 16'h0000;
      k_runs <= 8'h00;
    end else if (bus_k_drive) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      k_len <= run;
      k_runs <= k_runs + 8'h01;
      run <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* File: usb_device_suspend_resume_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module usb_device_suspend_resume_tb_top;
  import uds_pkg::*;
  localparam int IDLE_N = 20;
  localparam int PWR_N = 10;
  localparam int RWK_N = 16;
  localparam int OSC_N = 30;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic line_idle, line_k, wake_req, cs_n, vbus, osc_stable, osc_enable, clk_gate;
  logic suspend_out, power_switch_off, bus_k_drive, pullup_int_en, pullup_ext_en, irq;
  logic idle_cmd, resume_cmd;
  logic [15:0] k_len;
  logic [7:0] k_runs;
  logic [3:0] osc_cnt = 4'hf;
  int n_errors = 0;
  int n_compared = 0;

  assign hready = hreadyout;
  uds_suspend_resume #(.IDLE_CYC_P(TMR_W'(IDLE_N)), .POWER_OFF_SUSPEND_MODE_CYC_P(TMR_W'(PWR_N)),
    .RWAKE_CYC_P(TMR_W'(RWK_N)), .OSC_TMO_CYC_P(TMR_W'(OSC_N))) u_uds_suspend_resume (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_idle(line_idle),
    .line_k(line_k), .wake_req(wake_req), .cs_n(cs_n), .vbus(vbus),
    .osc_stable(osc_stable), .osc_enable(osc_enable), .clk_gate(clk_gate),
    .suspend_out(suspend_out), .power_switch_off(power_switch_off),
    .bus_k_drive(bus_k_drive), .pullup_int_en(pullup_int_en),
    .pullup_ext_en(pullup_ext_en), .irq(irq));
  uds_host_model u_uds_host_model (.hclk(hclk), .hresetn(hresetn), .idle_cmd(idle_cmd),
    .resume_cmd(resume_cmd), .bus_k_drive(bus_k_drive), .line_idle(line_idle),
    .line_k(line_k), .k_len(k_len), .k_runs(k_runs));

  // ==========================================================
  // Clock and oscillator that settles 8 cycles after enable
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    if (osc_enable !== 1'b1) osc_cnt <= 4'h0;
    else if (osc_cnt != 4'hf) osc_cnt <= osc_cnt + 4'h1;
  end
  assign osc_stable = (osc_cnt >= 4'h8);

  // ==========================================================
  // Bus tasks and checks
  task automatic tick(input int c);
    repeat (c) begin
      @(posedge hclk);
      #1;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(nm, q, exp);
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    logic kbad;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wake_req = 1'b0;
    cs_n = 1'b1;
    vbus = 1'b0;
    idle_cmd = 1'b0;
    resume_cmd = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd("status", ADDR_IRQ_STATUS, 32'h0);
    rd("mask", ADDR_IRQ_MASK, 32'h0);
    rd("mode", ADDR_MODE, 32'h0);
    rd("hwcfg", ADDR_HW_CONFIG, 32'h8);
    rd("state", ADDR_STATE, 32'h1);
    rd("unmapped", 8'h18, 32'h0);
    chk("ready_resp", {30'h0, hreadyout, hresp}, 32'h2);
    wr(ADDR_MODE, 32'h1);
    chk("pu_int", {31'h0, pullup_int_en}, 32'h1);
    wr(ADDR_HW_CONFIG, 32'h9);
    chk("pu_int_ext", {30'h0, pullup_int_en, pullup_ext_en}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1);
    idle_cmd <= 1'b1;
    tick(10);
    chk("early_susp", {31'h0, irq}, 32'h0);
    tick(IDLE_N);
    rd("susp_flag", ADDR_IRQ_STATUS, 32'h5);
    chk("susp_irq", {31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    rd("cleared", ADDR_IRQ_STATUS, 32'h4);
    wr(ADDR_HW_CONFIG, 32'h2);
    wr(ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_MODE, 32'h2);
    tick(2);
    chk("level_no_susp", {31'h0, suspend_out}, 32'h0);
    wr(ADDR_MODE, 32'h0);
    tick(2);
    chk("susp", {29'h0, suspend_out, osc_enable, clk_gate}, 32'h4);
    cs_n <= 1'b0;
    tick(10);
    chk("cs_no_vbus", {31'h0, suspend_out}, 32'h1);
    vbus <= 1'b1;
    n = 0;
    while (osc_enable !== 1'b1 && n < 40) begin tick(1); n++; end
    chk("osc_first", {30'h0, osc_enable, clk_gate}, 32'h2);
    n = 0;
    while (suspend_out !== 1'b0 && n < 60) begin tick(1); n++; end
    chk("clk_run", {30'h0, suspend_out, clk_gate}, 32'h1);
    idle_cmd <= 1'b0;
    cs_n <= 1'b1;
    tick(RWK_N + 4);
    chk("cs_k", {8'h00, k_runs, k_len}, {16'h0001, 16'(RWK_N)});
    rd("resm_flag", ADDR_IRQ_STATUS, 32'h2);
    chk("resm_irq", {31'h0, irq}, 32'h1);
    rd("locked", ADDR_STATE, 32'h21);
    wr(ADDR_IRQ_MASK, 32'h0);
    rd("mask_kept", ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_UNLOCK, 32'h1234);
    rd("bad_key", ADDR_STATE, 32'h21);
    wr(ADDR_UNLOCK, 32'haa37);
    rd("unlocked", ADDR_STATE, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h3);
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_HW_CONFIG, 32'h0);
    wr(ADDR_MODE, 32'h2);
    wr(ADDR_MODE, 32'h0);
    tick(2);
    resume_cmd <= 1'b1;
    n = 0;
    while (suspend_out !== 1'b0 && n < 60) begin tick(1); n++; end
    chk("host_wake", {31'h0, suspend_out}, 32'h0);
    resume_cmd <= 1'b0;
    tick(RWK_N + 4);
    chk("host_no_k", {24'h0, k_runs}, 32'h1);
    chk("resm_masked", {31'h0, irq}, 32'h0);
    wr(ADDR_UNLOCK, 32'haa37);
    wr(ADDR_HW_CONFIG, 32'h4);
    wr(ADDR_MODE, 32'h2);
    wr(ADDR_MODE, 32'h0);
    n = 0;
    while (suspend_out !== 1'b1 && n < 40) begin tick(1); n++; end
    chk("power_off_suspend_mode_wait", 32'(n >= PWR_N && n <= PWR_N + 2), 32'h1);
    chk("pwr_switch", {31'h0, power_switch_off}, 32'h1);
    wake_req <= 1'b1;
    n = 0;
    kbad = 1'b0;
    while ((suspend_out !== 1'b0 || bus_k_drive !== 1'b0 || n < 4) && n < 200) begin
      tick(1);
      n++;
      if (bus_k_drive === 1'b1 && (clk_gate !== 1'b1 || osc_stable !== 1'b1)) kbad = 1'b1;
    end
    wake_req <= 1'b0;
    chk("wake_time", 32'(n <= OSC_N + RWK_N + 4 && n < int'(WAKE_MAX_CYC)), 32'h1);
    chk("k_after_clk", {31'h0, kbad}, 32'h0);
    tick(2);
    chk("app_k", {8'h00, k_runs, k_len}, {16'h0002, 16'(RWK_N)});
    chk("pwr_on", {31'h0, power_switch_off}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
